// File: core/timer_b_device.sv
// timer b device end: counter, modes, capture and waveform output
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
// Summary of operation
// - debug halt stops timer unless run-while-halted
// - reset leaves periodic interrupt mode selected
// - enable starts counting on selected ticks
// - periodic: count to top, flag, restart
// - top below count: run to max, no flag
// - timeout: first edge restarts, second stops
// - timeout: flag when top reached before stop
// - frozen timeout: edge restarts, compare read strobe masked
// - capture on event: copy count, set flag
// - capture modes: compare register read clears flag
// - frequency: capture, restart, flag each edge
// - pulse width: rise restarts, fall captures
// - combined: rise starts, fall captures, rise stops
// - combined: read or clear arms new sequence
// - single shot: output high while counting
// - single shot: two cycle delay or asynchronous_detect
// - single shot: edge select any or rising
// - single shot: starts when enabled, unless top
// - event source holds pulse over one cycle
// - pwm: count zero to period, duty clears
// - pwm: period+1, zero low, duty>period high
// - software reprograms pwm while disabled
// - tick select: clock, half, timer a
// - other modes output idle level
module timer_b_device
  import timer_b_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link to host
  timer_b_if.device bus
);
  import timer_b_pkg::*;
  logic ev_rise;
  logic ev_fall;
  logic [15:0] count;
  logic [15:0] compare;
  logic flag;
  logic running;
  logic div2;
  logic tick;
  logic active;
  logic [1:0] phase;
  logic [1:0] ss_delay;
  logic wave;
  mode_t mode;
  logic trig;
  logic capt_mode;
  logic any_ev;
  logic set_flag;
  logic [7:0] duty;
  logic [7:0] period;
  logic [7:0] pwm_next;

  timer_b_edge u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .event_in(bus.event_in),
    .rise(ev_rise),
    .fall(ev_fall),
    .level()
  );

  assign mode = mode_t'(bus.mode);
  assign active = bus.enable & (~bus.cpu_halted | bus.run_while_halted);
  assign capt_mode = (mode == MODE_CAPT_EVT) || (mode == MODE_CAPT_FRQ) ||
    (mode == MODE_CAPT_PW) || (mode == MODE_CAPT_FRQPW);
  assign trig = bus.edge_sel ? ev_fall : ev_rise;
  assign any_ev = bus.capt_en & (bus.edge_sel ? (ev_rise | ev_fall) : ev_rise);
  assign period = compare[7:0];
  assign duty = compare[15:8];
  // output is registered, so it is decided from the count of the coming cycle
  assign pwm_next = (count[7:0] >= period) ? 8'h00 : count[7:0] + 8'h01;

  // tick source select; reserved code gives no ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div2 <= 1'b0;
    else
      div2 <= ~div2;
  end
  always_comb
  begin
    case (bus.tick_source_select)
      TICK_PER: tick = 1'b1;
      TICK_PER_DIV2: tick = div2;
      TICK_TIMER_A: tick = bus.timer_a_tick;
      default: tick = 1'b0;
    endcase
  end

  // counter, run state and capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= COUNT_RESET;
      compare <= COMPARE_RESET;
      running <= 1'b0;
      phase <= 2'h0;
      set_flag <= 1'b0;
    end
    else
    begin
      set_flag <= 1'b0;
      if (bus.cmp_wr)
        compare <= bus.cmp_wdata;
      if (bus.cnt_wr)
        count <= bus.cnt_wdata;
      else if (!active)
      begin
        running <= (mode == MODE_SINGLE) ? 1'b0 : running;
        phase <= 2'h0;
      end
      else
      begin
        case (mode)
          MODE_PERIODIC:
          begin
            running <= 1'b1;
            if (tick)
            begin
              if (count == compare)
              begin
                count <= COUNT_RESET;
                set_flag <= 1'b1;
              end
              else
                count <= count + 16'h0001; // wraps past max silently
            end
          end
          MODE_TIMEOUT:
          begin
            if (bus.capt_en && trig)
            begin
              running <= (phase != 2'h1); // second edge freezes, next restarts
              phase <= (phase == 2'h1) ? 2'h0 : 2'h1;
              if (phase != 2'h1)
                count <= COUNT_RESET;
            end
            else if (running && tick)
            begin
              count <= count + 16'h0001;
              if (count + 16'h0001 == compare)
                set_flag <= 1'b1;
            end
          end
          MODE_CAPT_EVT:
          begin
            running <= 1'b1;
            if (tick)
              count <= count + 16'h0001;
            if (bus.capt_en && trig)
            begin
              compare <= count;
              set_flag <= 1'b1;
            end
          end
          MODE_CAPT_FRQ:
          begin
            running <= 1'b1;
            if (bus.capt_en && trig)
            begin
              compare <= count;
              count <= COUNT_RESET;
              set_flag <= 1'b1;
            end
            else if (tick)
              count <= count + 16'h0001;
          end
          MODE_CAPT_PW:
          begin
            running <= 1'b1;
            if (bus.capt_en && ev_rise)
              count <= COUNT_RESET;
            else if (bus.capt_en && ev_fall)
            begin
              compare <= count;
              set_flag <= 1'b1;
            end
            else if (tick)
              count <= count + 16'h0001;
          end
          MODE_CAPT_FRQPW:
          begin
            if (phase == 2'h3 && (bus.flag_clr || bus.cmp_hi_rd))
              phase <= 2'h0;
            else if (bus.capt_en && ev_rise && phase == 2'h0)
            begin
              count <= COUNT_RESET;
              running <= 1'b1;
              phase <= 2'h1;
            end
            else if (bus.capt_en && ev_fall && phase == 2'h1)
            begin
              compare <= count;
              phase <= 2'h2;
            end
            else if (bus.capt_en && ev_rise && phase == 2'h2)
            begin
              running <= 1'b0;
              set_flag <= 1'b1;
              phase <= 2'h3;
            end
            if (running && tick && !(bus.capt_en && ev_rise))
              count <= count + 16'h0001;
          end
          MODE_SINGLE:
          begin
            if (!running && any_ev && !wave)
            begin
              count <= COUNT_RESET; // events while output still high are ignored
              running <= 1'b1;
            end
            else if (running && tick)
            begin
              if (count == compare)
                running <= 1'b0;
              else
                count <= count + 16'h0001;
            end
            else if (!running && count != compare && tick)
              running <= 1'b1; // starts at enable unless count holds top
          end
          MODE_PWM8:
          begin
            running <= 1'b1;
            if (tick)
              count <= (count[7:0] >= period) ? COUNT_RESET : count + 16'h0001;
          end
          default: running <= 1'b0;
        endcase
      end
    end
  end

  // capture flag: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag <= 1'b0;
    else if (set_flag)
      flag <= 1'b1;
    else if (bus.flag_clr || (capt_mode && bus.cmp_hi_rd))
      flag <= 1'b0;
  end

  // waveform output; single shot rises two clocks after run rises unless asynchronous_detect
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wave <= 1'b0;
      ss_delay <= 2'h0;
    end
    else
    begin
      ss_delay <= {ss_delay[0], running};
      case (mode)
        MODE_SINGLE: wave <= bus.asynchronous_detect ? running : ss_delay[0];
        MODE_PWM8:
          wave <= (period != 8'h00) && (duty != 8'h00) &&
            (({8'h00, duty} > {8'h00, period}) || (pwm_next < duty));
        default: wave <= bus.idle_output_level;
      endcase
    end
  end

  assign bus.counter_value = count;
  assign bus.capture_compare_value = compare;
  assign bus.capt_flag = flag;
  assign bus.run = running;
  assign bus.waveform_out = wave;
endmodule // timer_b_device

// File: core/timer_b_pkg.sv
// package: constants, modes and types shared by the timer b ends
package timer_b_pkg;
  localparam int CNT_W = 16;
  // mode encodings
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_CAPT_EVT = 3'h2,
    MODE_CAPT_FRQ = 3'h3,
    MODE_CAPT_PW = 3'h4,
    MODE_CAPT_FRQPW = 3'h5,
    MODE_SINGLE = 3'h6,
    MODE_PWM8 = 3'h7
  } mode_t;
  // tick source select encodings
  localparam logic [1:0] TICK_PER = 2'h0;
  localparam logic [1:0] TICK_PER_DIV2 = 2'h1;
  localparam logic [1:0] TICK_TIMER_A = 2'h2;
  localparam logic [1:0] TICK_RESERVED = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam mode_t MODE_RESET = MODE_PERIODIC;
  // AHB-Lite register byte offsets of the controller
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EVCTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_COMPARE = 8'h10;
  localparam logic [7:0] OFS_EVENT = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  // ctrl field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_TSEL_LO = 1;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_IDLE_LVL = 7;
  localparam int CTRL_ASYNCHRONOUS_DETECT = 8;
  localparam int CTRL_RUN_HALTED = 9;
  localparam int CTRL_HALT = 10;
  localparam int EV_CAPT_EN = 0;
  localparam int EV_EDGE = 1;
  // minimum event pulse in system clocks
  localparam int EVENT_MIN_HOLD = 2;
endpackage

// File: core/timer_b_if.sv
// interface: register access lines, event line and waveform out between the ends
`timescale 1ns/1ps
interface timer_b_if;
  logic enable;
  logic [1:0] tick_source_select;
  logic [2:0] mode;
  logic idle_output_level;
  logic asynchronous_detect;
  logic run_while_halted;
  logic cpu_halted;
  logic capt_en;
  logic edge_sel;
  logic timer_a_tick;
  logic event_in;
  logic cnt_wr;
  logic [15:0] cnt_wdata;
  logic cmp_wr;
  logic [15:0] cmp_wdata;
  logic cmp_hi_rd;
  logic flag_clr;
  logic [15:0] counter_value;
  logic [15:0] capture_compare_value;
  logic capt_flag;
  logic run;
  logic waveform_out;
  modport device (
    input enable, tick_source_select, mode, idle_output_level, asynchronous_detect,
    input run_while_halted, cpu_halted, capt_en, edge_sel, timer_a_tick, event_in,
    input cnt_wr, cnt_wdata, cmp_wr, cmp_wdata, cmp_hi_rd, flag_clr,
    output counter_value, capture_compare_value, capt_flag, run, waveform_out
  );
  modport host (
    output enable, tick_source_select, mode, idle_output_level, asynchronous_detect,
    output run_while_halted, cpu_halted, capt_en, edge_sel, timer_a_tick, event_in,
    output cnt_wr, cnt_wdata, cmp_wr, cmp_wdata, cmp_hi_rd, flag_clr,
    input counter_value, capture_compare_value, capt_flag, run, waveform_out
  );
endinterface

// File: core/timer_b_edge.sv
// event input synchroniser and edge detector
`timescale 1ns/1ps
module timer_b_edge (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // event line
  input wire logic event_in,
  // detected edges
  output logic rise,
  output logic fall,
  output logic level
);
  logic sync_a;
  logic sync_b;
  logic prev;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      sync_a <= event_in;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end
  assign rise = sync_b & ~prev;
  assign fall = ~sync_b & prev;
  assign level = sync_b;
endmodule // timer_b_edge

// File: core/timer_b_host.sv
// timer b controller end: AHB-Lite registers driving the device link
`timescale 1ns/1ps
module timer_b_host
  import timer_b_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link to device
  timer_b_if.host dev
);
  import timer_b_pkg::*;
  logic [10:0] ctrl;
  logic [1:0] evctrl;
  logic [7:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic ev_out;
  logic frozen;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // frozen timeout state keeps compare reads from raising cmp_hi_rd
  assign frozen = (ctrl[CTRL_MODE_LO +: 3] == 3'(MODE_TIMEOUT)) && !dev.run;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= hsel && htrans[1] && hwrite;
      rd_q <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= {8'h00, 3'(MODE_RESET)} << CTRL_MODE_LO;
      evctrl <= 2'h0;
      ev_out <= 1'b0;
    end
    else if (wr_q)
    begin
      case (addr_q)
        OFS_CTRL: ctrl <= hwdata[10:0];
        OFS_EVCTRL: evctrl <= hwdata[1:0];
        OFS_EVENT: ev_out <= hwdata[0];
        default: ev_out <= ev_out;
      endcase
    end
  end

  // status, count, compare and flag read data are taken straight from the link
  always_comb
  begin
    case (addr_q)
      OFS_CTRL: hrdata = {21'h0, ctrl};
      OFS_EVCTRL: hrdata = {30'h0, evctrl};
      OFS_STATUS: hrdata = {30'h0, dev.waveform_out, dev.run};
      OFS_COUNT: hrdata = {16'h0, dev.counter_value};
      OFS_COMPARE: hrdata = {16'h0, dev.capture_compare_value};
      OFS_EVENT: hrdata = {31'h0, ev_out};
      OFS_FLAG: hrdata = {31'h0, dev.capt_flag};
      default: hrdata = 32'h0;
    endcase
  end

  assign dev.enable = ctrl[CTRL_ENABLE];
  assign dev.tick_source_select = ctrl[CTRL_TSEL_LO +: 2];
  assign dev.mode = ctrl[CTRL_MODE_LO +: 3];
  assign dev.idle_output_level = ctrl[CTRL_IDLE_LVL];
  assign dev.asynchronous_detect = ctrl[CTRL_ASYNCHRONOUS_DETECT];
  assign dev.run_while_halted = ctrl[CTRL_RUN_HALTED];
  assign dev.cpu_halted = ctrl[CTRL_HALT];
  assign dev.capt_en = evctrl[EV_CAPT_EN];
  assign dev.edge_sel = evctrl[EV_EDGE];
  assign dev.timer_a_tick = 1'b0;
  assign dev.event_in = ev_out; // held until software rewrites it
  assign dev.cnt_wr = wr_q && (addr_q == OFS_COUNT);
  assign dev.cnt_wdata = hwdata[15:0];
  assign dev.cmp_wr = wr_q && (addr_q == OFS_COMPARE);
  assign dev.cmp_wdata = hwdata[15:0];
  assign dev.cmp_hi_rd = rd_q && (addr_q == OFS_COMPARE) && !frozen;
  assign dev.flag_clr = wr_q && (addr_q == OFS_FLAG) && hwdata[0];
endmodule // timer_b_host

// File: testbench/timer_b_assertions.sv
// checker: timing relations on the link between the timer b ends
`timescale 1ns/1ps
module timer_b_assertions
  import timer_b_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control from the host end
  input wire logic enable,
  input wire logic [1:0] tick_source_select,
  input wire logic [2:0] mode,
  input wire logic idle_output_level,
  input wire logic run_while_halted,
  input wire logic cpu_halted,
  input wire logic event_in,
  input wire logic cnt_wr,
  input wire logic cmp_wr,
  input wire logic cmp_hi_rd,
  // device state
  input wire logic [15:0] counter_value,
  input wire logic [15:0] capture_compare_value,
  input wire logic capt_flag,
  input wire logic run,
  input wire logic waveform_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] quiet;
  logic per_run;
  assign per_run = enable && mode == MODE_PERIODIC && !cnt_wr && !cmp_wr
    && !(cpu_halted && !run_while_halted);
  // edges pass three flops, so only a long-settled line rules out a fresh capture
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      quiet <= 3'h0;
    else if ($changed(event_in))
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  sequence s_halted;
    (cpu_halted && !run_while_halted && !cnt_wr)[*2];
  endsequence
  sequence s_full_rate;
    (per_run && tick_source_select == TICK_PER)[*2];
  endsequence
  sequence s_at_top;
    s_full_rate ##0 counter_value == capture_compare_value;
  endsequence
  sequence s_half_tick;
    per_run && tick_source_select == TICK_PER_DIV2 && $changed(counter_value)
    && $past(per_run) && $past(tick_source_select) == TICK_PER_DIV2
    ##1 per_run && tick_source_select == TICK_PER_DIV2;
  endsequence
  sequence s_plain_mode;
    (mode != MODE_SINGLE && mode != MODE_PWM8 && $stable(mode)
    && $stable(idle_output_level))[*2];
  endsequence
  sequence s_shot_stopped;
    (mode == MODE_SINGLE && !run && $stable(mode))[*3];
  endsequence
  chk_halt_hold: assert property (s_halted |-> $stable(counter_value))
    else $error("counter moved while halted");
  chk_count_step: assert property (s_full_rate ##0 counter_value != capture_compare_value
    |=> counter_value == $past(counter_value) + 16'h1)
    else $error("counter did not step by one");
  chk_top_restart: assert property (s_at_top |=> counter_value == 16'h0)
    else $error("counter did not restart after top");
  chk_top_flag: assert property (s_at_top |-> ##[0:2] capt_flag)
    else $error("no flag at top");
  chk_half_rate: assert property (s_half_tick |-> $stable(counter_value))
    else $error("halved tick counted twice in a row");
  chk_idle_level: assert property (s_plain_mode |-> waveform_out == idle_output_level)
    else $error("output not at idle level");
  chk_shot_low: assert property (s_shot_stopped |-> !waveform_out)
    else $error("single shot output high while stopped");
  chk_read_clears: assert property (mode >= 3'h2 && mode <= 3'h5 && $stable(mode)
    && cmp_hi_rd && quiet == 3'h7 |=> !capt_flag)
    else $error("capture read left flag set");
endmodule // timer_b_assertions

// File: testbench/test_timer_b_capture_pwm_modes.sv
// testbench: both timer b ends joined, driven over the register bus
`timescale 1ns/1ps
module test_timer_b_capture_pwm_modes;
  import timer_b_pkg::*;
  localparam logic [31:0] EN = 32'h1;
  localparam logic [31:0] IDLE = 32'h1 << CTRL_IDLE_LVL;
  localparam logic [31:0] HALT = 32'h1 << CTRL_HALT;
  localparam logic [31:0] RUN_HALTED = 32'h1 << CTRL_RUN_HALTED;
  localparam int LIMIT = 20000;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  int fails, checked, cycles, seed, top, a, g;
  logic [15:0] pw[$] = '{16'h0309, 16'h0009, 16'h0a09, 16'h0500};
  logic [1:0] tsl[5] = '{TICK_PER_DIV2, TICK_TIMER_A, TICK_PER, TICK_PER, TICK_RESERVED};
  logic [31:0] flg[5] = '{32'h0, 32'h0, HALT, HALT | RUN_HALTED, 32'h0};
  int dlt[5] = '{1, 0, 0, 2, 0};
  timer_b_if link();
  timer_b_host i_timer_b_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dev(link));
  timer_b_device i_timer_b_device (.hclk(hclk), .hresetn(hresetn), .bus(link));
  timer_b_assertions i_timer_b_assertions (.hclk(hclk), .hresetn(hresetn),
    .enable(link.enable), .tick_source_select(link.tick_source_select), .mode(link.mode),
    .idle_output_level(link.idle_output_level), .run_while_halted(link.run_while_halted),
    .cpu_halted(link.cpu_halted), .event_in(link.event_in), .cnt_wr(link.cnt_wr),
    .cmp_wr(link.cmp_wr), .cmp_hi_rd(link.cmp_hi_rd), .counter_value(link.counter_value),
    .capture_compare_value(link.capture_compare_value), .capt_flag(link.capt_flag),
    .run(link.run), .waveform_out(link.waveform_out));
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic summarize;
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      summarize();
    end
  end
  // called just after an edge; returns at the edge that closes the data phase
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad);
    xfer(1'b0, ad, 32'h0);
  endtask
  task automatic expect_eq(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      fails++;
      $display("unexpected at %0t: read %h, model %h", $time, got, want);
    end
  endtask
  task automatic setup(input logic [2:0] m, input logic [1:0] t, input logic [31:0] f);
    wr(OFS_CTRL, (32'(m) << CTRL_MODE_LO) | (32'(t) << CTRL_TSEL_LO) | f);
  endtask
  // reads are two cycles apart, so the model steps by ticks per two cycles
  task automatic track(input int step, input int span, input int n);
    int base;
    rd(OFS_COUNT);
    base = int'(r[15:0]);
    repeat (n)
    begin
      base = (base + step) % span;
      rd(OFS_COUNT);
      expect_eq(r, 32'(base));
    end
  endtask
  initial
  begin
    seed = 32'h99cd;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 8'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4));
      expect_eq(r, 32'h0);
      expect_eq(32'(hresp), 32'h0);
    end
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c);
    expect_eq(r, 32'h0);
    top = 5 + int'($unsigned($random(seed)) % 8);
    wr(OFS_COMPARE, 32'(top));
    setup(MODE_PERIODIC, TICK_PER, EN | IDLE);
    track(2, top + 1, 8);
    rd(OFS_FLAG);
    expect_eq(r, 32'h1);
    rd(OFS_STATUS);
    expect_eq(32'(r[1]), 32'h1);
    wr(OFS_COMPARE, 32'h40);
    wr(OFS_FLAG, 32'h1);
    wr(OFS_COUNT, 32'hfff8);
    track(2, 65536, 6);
    rd(OFS_FLAG);
    expect_eq(r, 32'h0);
    repeat (80) @(posedge hclk);
    rd(OFS_FLAG);
    expect_eq(r, 32'h1);
    wr(OFS_COMPARE, 32'hffff);
    for (int i = 0; i < 5; i++)
    begin
      setup(MODE_PERIODIC, tsl[i], EN | flg[i]);
      track(dlt[i], 65536, 3);
    end
    for (int m = 2; m < 4; m++)
      for (int p = 0; p < 2; p++)
      begin
        wr(OFS_EVENT, 32'(p));
        wr(OFS_EVCTRL, 32'h1 | 32'(p << EV_EDGE));
        setup(3'(m), TICK_PER, EN);
        wr(OFS_FLAG, 32'h1);
        rd(OFS_COUNT);
        a = int'(r[15:0]);
        wr(OFS_EVENT, 32'(1 - p));
        repeat (6) @(posedge hclk);
        rd(OFS_FLAG);
        expect_eq(r, 32'h1);
        rd(OFS_COMPARE);
        expect_eq(32'(r >= a + 2 && r <= a + 11), 32'h1);
        rd(OFS_FLAG);
        expect_eq(r, 32'h0);
        if (m == 3)
        begin
          rd(OFS_COUNT);
          expect_eq(32'(r < 32'h18), 32'h1);
        end
      end
    wr(OFS_EVCTRL, 32'h1);
    for (int m = 4; m < 6; m++)
    begin
      setup(3'(m), TICK_PER, EN);
      wr(OFS_FLAG, 32'h1);
      g = 4 + int'($unsigned($random(seed)) % 16);
      wr(OFS_EVENT, 32'h1);
      repeat (g) @(posedge hclk);
      wr(OFS_EVENT, 32'h0);
      repeat (8) @(posedge hclk);
      rd(OFS_FLAG);
      expect_eq(r, 32'(m == 4));
      wr(OFS_EVENT, 32'h1);
      repeat (8) @(posedge hclk);
      rd(OFS_FLAG);
      expect_eq(r, 32'h1);
      if (m == 5)
        track(0, 65536, 2);
      rd(OFS_COMPARE);
      expect_eq(32'(r >= g + 1 && r <= g + 3), 32'h1);
      rd(OFS_FLAG);
      expect_eq(r, 32'h0);
      wr(OFS_EVENT, 32'h0);
      repeat (8) @(posedge hclk);
    end
    wr(OFS_COMPARE, 32'h30);
    setup(MODE_TIMEOUT, TICK_PER, EN);
    wr(OFS_FLAG, 32'h1);
    // first rise restarts, second freezes; the long gap passes top before freezing
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_EVENT, 32'h1);
      repeat (8) @(posedge hclk);
      rd(OFS_COUNT);
      expect_eq(32'(r < 32'h10), 32'h1);
      wr(OFS_EVENT, 32'h0);
      repeat (k * 50) @(posedge hclk);
      wr(OFS_EVENT, 32'h1);
      repeat (8) @(posedge hclk);
      track(0, 65536, 1);
      rd(OFS_FLAG);
      expect_eq(r, 32'(k));
      wr(OFS_EVENT, 32'h0);
    end
    wr(OFS_COMPARE, 32'h28);
    for (int e = 0; e < 2; e++)
    begin
      wr(OFS_EVCTRL, 32'h1 | 32'(e << EV_EDGE));
      setup(MODE_SINGLE, TICK_PER, 32'h0);
      wr(OFS_COUNT, 32'h28);
      setup(MODE_SINGLE, TICK_PER, EN | (32'($random(seed) & 1) << CTRL_ASYNCHRONOUS_DETECT));
      rd(OFS_STATUS);
      expect_eq(r, 32'h0);
      wr(OFS_EVENT, 32'h1);
      repeat (8) @(posedge hclk);
      rd(OFS_STATUS);
      expect_eq(r, 32'h3);
      repeat (60) @(posedge hclk);
      rd(OFS_STATUS);
      expect_eq(r, 32'h0);
      wr(OFS_EVENT, 32'h0);
      repeat (8) @(posedge hclk);
      rd(OFS_STATUS);
      expect_eq(r, 32'(e * 3));
      repeat (60) @(posedge hclk);
    end
    top = 4 + int'($unsigned($random(seed)) % 12);
    pw.push_back({8'(1 + $unsigned($random(seed)) % top), 8'(top)});
    foreach (pw[i])
    begin
      setup(MODE_PWM8, TICK_PER, 32'h0);
      wr(OFS_COMPARE, 32'(pw[i]));
      wr(OFS_COUNT, 32'h0);
      setup(MODE_PWM8, TICK_PER, EN);
      repeat (20) @(posedge hclk);
      top = int'(pw[i][7:0]);
      g = int'(pw[i][15:8]);
      a = 0;
      repeat (4 * (top + 1))
      begin
        @(posedge hclk);
        a += int'(link.waveform_out === 1'b1);
      end
      g = top == 0 ? 0 : (g > top ? 4 * (top + 1) : 4 * g);
      expect_eq(32'(a), 32'(g));
    end
    summarize();
  end
endmodule // test_timer_b_capture_pwm_modes
